// [hw/amd_core.sv]
// audio fixed-point mac datapath: coefficient RAM, data RAM, fixed program, ALU, output FIFO
// assumes coefficient writes arrive already decoded from the serial control bus
`timescale 1ns/10ps
// Functional notes
// - samples are 32-bit two's complement, sign in top bit
// - gain multiplies 32-bit sample by 28-bit coefficient, full product kept
// - standalone gain product truncated from 60 to 32 bits, no rounding
// - level offset adds 28-bit signed coefficient to 32-bit gain result
// - offset overflow clamps to max positive or most negative
// - word has four guard bits on top, four noise bits below
// - input msb sits just under the guard boundary, sign extended
// - multiplies always combine 9.23 data with 5.23 coefficient
// - summed products go into a 60-bit accumulate adder
// - accumulator never saturates, wraps in two's complement
// - biquads are direct form I with one accumulation node
// - memory: dual-port data RAM, coefficient RAM, fixed program ROM
// - only coefficient RAM is reachable from the host
// - coefficients are 28-bit 5.23 two's complement
// - coefficient with top bit set is negative
// - integer part is one hex digit plus next digit's top bit
// - default processing at double rate, 96 or 88.2 kHz from master clock
// - native high-rate mode: only four channels processed, middle ones pass
// - output mixer: two sources for first six channels, three for last two
// - unused top four coefficient bits written zero and reset to zero
module amd_core (
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    input  wire amd_pkg::amd_coef_wr_t coef_wr,
    input  wire logic                  mclk_family_48k,
    input  wire logic                  native_hi_rate,
    input  wire logic                  in_valid,
    output logic                       in_ready,
    input  wire logic                  [amd_pkg::IN_W-1:0] in_sample,
    output logic                       rate_is_96k,
    output logic                       out_valid,
    input  wire logic                  out_ready,
    output amd_pkg::amd_sample_t       out_data,
    output logic                       mac_busy
);
    // ****************************************************************
    // memories
    // ****************************************************************
    logic [amd_pkg::COEF_WORD_W-1:0] coef_ram [amd_pkg::COEF_DEPTH];
    logic [amd_pkg::DATA_W-1:0]      data_ram [amd_pkg::DATA_DEPTH];
    amd_pkg::amd_instr_t             prog_rom [amd_pkg::PROG_DEPTH];

    // fixed program: a direct form I biquad, b0 x0 + b1 x1 + b2 x2 + a1 y1 + a2 y2
    // data slots 0..4 hold x0 x1 x2 y1 y2, slot 5 the result; fixed, no host path
    // offset acts on the gain result in res_q; its data slot is not read
    // slot 8 is the first NOP, which ends the pass
    always_comb begin
        prog_rom[0]  = '{amd_pkg::AMD_OP_MAC_CLR, 8'h00, 6'h00};
        prog_rom[1]  = '{amd_pkg::AMD_OP_MAC,     8'h01, 6'h01};
        prog_rom[2]  = '{amd_pkg::AMD_OP_MAC,     8'h02, 6'h02};
        prog_rom[3]  = '{amd_pkg::AMD_OP_MAC,     8'h03, 6'h03};
        prog_rom[4]  = '{amd_pkg::AMD_OP_MAC,     8'h04, 6'h04};
        prog_rom[5]  = '{amd_pkg::AMD_OP_STORE,   8'h00, 6'h05};
        prog_rom[6]  = '{amd_pkg::AMD_OP_GAIN,    8'h05, 6'h05};
        prog_rom[7]  = '{amd_pkg::AMD_OP_OFFSET,  8'h06, 6'h05};
        for (int i = 8; i < amd_pkg::PROG_DEPTH; i++) begin
            prog_rom[i] = '{amd_pkg::AMD_OP_NOP, 8'h00, 6'h00};
        end
    end

    // ****************************************************************
    // coefficient RAM, host write port
    // ****************************************************************
    logic                         coef_init_q, coef_init_d;
    logic [amd_pkg::COEF_AW-1:0]  init_addr_q, init_addr_d;

    always_comb begin
        coef_init_d = coef_init_q;
        init_addr_d = init_addr_q;
        if (coef_init_q) begin
            init_addr_d = init_addr_q + 1'b1;
            if (init_addr_q == 8'hFF) begin
                coef_init_d = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            coef_init_q <= 1'b1;
            init_addr_q <= '0;
        end else begin
            coef_init_q <= coef_init_d;
            init_addr_q <= init_addr_d;
        end
    end

    logic coef_host_we;

    // host writes are dropped while the clear walks the RAM (256 cycles)
    assign coef_host_we = coef_wr.wr && !coef_init_q;

    // clears the RAM after reset
    always_ff @(posedge clk) begin
        if (coef_init_q) begin
            coef_ram[init_addr_q] <= amd_pkg::COEF_RST;
        end else if (coef_host_we) begin
            // top nibble forced to zero whatever the host sent
            coef_ram[coef_wr.addr] <= {4'h0, coef_wr.word[amd_pkg::COEF_W-1:0]};
        end
    end

    // ****************************************************************
    // rate selection
    // ****************************************************************
    logic fam_s1_q, fam_s2_q;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            fam_s1_q <= 1'b0;
            fam_s2_q <= 1'b0;
        end else begin
            fam_s1_q <= mclk_family_48k;
            fam_s2_q <= fam_s1_q;
        end
    end

    assign rate_is_96k = fam_s2_q;

    // ****************************************************************
    // sequencer
    // ****************************************************************
    typedef enum {
        AMD_IDLE,
        AMD_RUN,
        AMD_EMIT
    } amd_state_t;

    amd_state_t                        st_q, st_d;
    logic [amd_pkg::PROG_AW-1:0]       pc_q, pc_d;
    logic [amd_pkg::CH_AW-1:0]         ch_q, ch_d;
    logic signed [amd_pkg::PROD_W-1:0] acc_q, acc_d;
    logic [amd_pkg::DATA_W-1:0]        res_q, res_d;
    logic                              fifo_in_ready;
    logic                              emit_valid;
    logic                              bypass_ch;
    amd_pkg::amd_instr_t               ins;
    logic signed [amd_pkg::DATA_W-1:0] dword;
    logic signed [amd_pkg::COEF_W-1:0] cword;
    logic signed [amd_pkg::PROD_W-1:0] prod;
    logic signed [amd_pkg::DATA_W:0]   sum33;
    logic [amd_pkg::DATA_W-1:0]        aligned;

    // sign extend into the guard bits, zero the noise bits
    assign aligned = {{amd_pkg::GUARD_BITS{in_sample[amd_pkg::IN_W-1]}}, in_sample,
                      {amd_pkg::NOISE_BITS{1'b0}}};

    // in native high rate only channels 0,1,6,7 run the program
    assign bypass_ch = native_hi_rate && (ch_q >= 3'h2) && (ch_q <= 3'h5);

    // ****************************************************************
    // ALU: one multiplier, 60-bit accumulate, 33-bit offset adder
    // ****************************************************************
    assign ins   = prog_rom[pc_q];
    assign dword = data_ram[ins.data_addr];
    assign cword = coef_ram[ins.coef_addr][amd_pkg::COEF_W-1:0];
    assign prod  = dword * cword;
    // offset is added to the gain result already held in res_q
    assign sum33 = {res_q[amd_pkg::DATA_W-1], res_q}
                 + {{5{cword[amd_pkg::COEF_W-1]}}, cword};

    logic [amd_pkg::DATA_W-1:0]        off_res;

    // clamp rather than wrap when the sum leaves the 32-bit range
    always_comb begin
        off_res = sum33[amd_pkg::DATA_W-1:0];
        if (sum33[amd_pkg::DATA_W] != sum33[amd_pkg::DATA_W-1]) begin
            off_res = sum33[amd_pkg::DATA_W] ? amd_pkg::SAT_NEG : amd_pkg::SAT_POS;
        end
    end

    // one sample per pass: refused until its result is queued
    assign in_ready   = (st_q == AMD_IDLE);
    assign emit_valid = (st_q == AMD_EMIT);
    assign mac_busy   = (st_q == AMD_RUN);

    // ****************************************************************
    // sequencer next state
    // ****************************************************************

    always_comb begin
        st_d  = st_q;
        pc_d  = pc_q;
        ch_d  = ch_q;
        acc_d = acc_q;
        res_d = res_q;
        unique case (st_q)
            AMD_IDLE: begin
                if (in_valid) begin
                    pc_d = '0;
                    if (bypass_ch) begin
                        res_d = aligned;
                        st_d  = AMD_EMIT;
                    end else begin
                        st_d = AMD_RUN;
                    end
                end
            end
            AMD_RUN: begin
                pc_d = pc_q + 1'b1;
                unique case (ins.op)
                    amd_pkg::AMD_OP_MAC_CLR: acc_d = prod;
                    // wraps on purpose; only the final sum has to fit
                    amd_pkg::AMD_OP_MAC:     acc_d = acc_q + prod;
                    amd_pkg::AMD_OP_STORE: begin
                        // 5.23 times 9.23 leaves 46 fraction bits; keep 9.23
                        res_d = acc_q[amd_pkg::FRAC_BITS +: amd_pkg::DATA_W];
                    end
                    amd_pkg::AMD_OP_GAIN: begin
                        res_d = prod[amd_pkg::FRAC_BITS +: amd_pkg::DATA_W];
                    end
                    amd_pkg::AMD_OP_OFFSET: begin
                        res_d = off_res;
                    end
                    default: begin
                        st_d = AMD_EMIT;
                    end
                endcase
            end
            AMD_EMIT: begin
                // waits here while the fifo is full; nothing is dropped
                if (fifo_in_ready) begin
                    ch_d = ch_q + 1'b1;
                    st_d = AMD_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_q  <= AMD_IDLE;
            pc_q  <= '0;
            ch_q  <= '0;
            acc_q <= '0;
            res_q <= '0;
        end else begin
            st_q  <= st_d;
            pc_q  <= pc_d;
            ch_q  <= ch_d;
            acc_q <= acc_d;
            res_q <= res_d;
        end
    end

    // ****************************************************************
    // data RAM: port A takes the new sample, port B writes the result
    // ****************************************************************
    logic                       wa_en;
    logic                       wb_en;
    logic [amd_pkg::DATA_W-1:0] wb_word;

    assign wa_en   = (st_q == AMD_IDLE) && in_valid;
    assign wb_en   = (st_q == AMD_RUN) && (ins.op == amd_pkg::AMD_OP_STORE);
    assign wb_word = acc_q[amd_pkg::FRAC_BITS +: amd_pkg::DATA_W];

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            // history starts at zero, else the first passes multiply unknowns
            for (int i = 0; i < amd_pkg::DATA_DEPTH; i++) begin
                data_ram[i] <= '0;
            end
        end else begin
            if (wa_en) begin
                data_ram[0] <= aligned;
                data_ram[1] <= data_ram[0];
                data_ram[2] <= data_ram[1];
            end
            if (wb_en) begin
                data_ram[3] <= wb_word;
                data_ram[4] <= data_ram[3];
                data_ram[ins.data_addr] <= wb_word;
            end
        end
    end

    // ****************************************************************
    // output FIFO
    // ****************************************************************
    amd_pkg::amd_sample_t emit_word;
    assign emit_word = '{ch: ch_q, sample: res_q};

    amd_fifo #(
        .WIDTH ($bits(amd_pkg::amd_sample_t)),
        .DEPTH (amd_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst_b     (rst_b),
        .in_valid  (emit_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (emit_word),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (out_data)
    );

    // the output mixer (2 sources ch0-5, 3 sources ch6-7) sits downstream;
    // the channel tag on each word lets it pick its sources
endmodule

// [hw/amd_fifo.sv]
// parameterised valid/ready FIFO for output samples
// assumes writer and reader share clk; synchronous active-low reset
`timescale 1ns/10ps
module amd_fifo #(
    parameter int WIDTH = 35,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wp_q, wp_d, rp_q, rp_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic             push, pop;

    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rp_q];

    always_comb begin
        wp_d  = push ? wp_q + 1'b1 : wp_q;
        rp_d  = pop ? rp_q + 1'b1 : rp_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_q] <= in_data;
        end
    end
endmodule

// [hw/amd_pkg.sv]
// package for the audio mac datapath: formats, memory sizes, op codes, carriers
// assumes a single 100 MHz clock domain and no software register map
package amd_pkg;

    localparam int DATA_W      = 32;
    localparam int COEF_W      = 28;
    localparam int COEF_WORD_W = 32;
    localparam int PROD_W      = 60;
    localparam int GUARD_BITS  = 4;
    localparam int NOISE_BITS  = 4;
    localparam int FRAC_BITS   = 23;
    localparam int IN_W        = DATA_W - GUARD_BITS - NOISE_BITS;
    localparam int IN_MSB_POS  = DATA_W - GUARD_BITS - 1;
    localparam int NUM_CH      = 8;
    localparam int NUM_SRC     = 8;
    localparam int COEF_DEPTH  = 256;
    localparam int COEF_AW     = 8;
    localparam int DATA_DEPTH  = 64;
    localparam int DATA_AW     = 6;
    localparam int PROG_DEPTH  = 16;
    localparam int PROG_AW     = 4;
    localparam int FIFO_DEPTH  = 16;
    localparam int CH_AW       = 3;

    localparam logic [DATA_W-1:0] SAT_POS = 32'h7FFFFFFF;
    localparam logic [DATA_W-1:0] SAT_NEG = 32'h80000000;
    localparam logic [COEF_WORD_W-1:0] COEF_RST = 32'h00000000;

    typedef enum logic [2:0] {
        AMD_OP_NOP,
        AMD_OP_GAIN,
        AMD_OP_OFFSET,
        AMD_OP_MAC_CLR,
        AMD_OP_MAC,
        AMD_OP_STORE
    } amd_op_t;

    typedef struct packed {
        amd_op_t              op;
        logic [COEF_AW-1:0]   coef_addr;
        logic [DATA_AW-1:0]   data_addr;
    } amd_instr_t;

    typedef struct packed {
        logic [CH_AW-1:0]  ch;
        logic [DATA_W-1:0] sample;
    } amd_sample_t;

    typedef struct packed {
        logic                   wr;
        logic [COEF_AW-1:0]     addr;
        logic [COEF_WORD_W-1:0] word;
    } amd_coef_wr_t;

endpackage

// [tb/amd_core_assertions.sv]
// checker for the mac datapath top ports
// assumes a single clk domain and synchronous active-low rst_b
`timescale 1ns/10ps
module amd_core_chk (
    input wire logic                     clk,
    input wire logic                     rst_b,
    input wire amd_pkg::amd_coef_wr_t    coef_wr,
    input wire logic                     mclk_family_48k,
    input wire logic                     native_hi_rate,
    input wire logic                     in_valid,
    input wire logic                     in_ready,
    input wire logic [amd_pkg::IN_W-1:0] in_sample,
    input wire logic                     rate_is_96k,
    input wire logic                     out_valid,
    input wire logic                     out_ready,
    input wire amd_pkg::amd_sample_t     out_data,
    input wire logic                     mac_busy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    wire logic take = in_valid && in_ready;

    a_reset_idle: assert property (disable iff (1'b0) !rst_b |=> in_ready && !out_valid && !mac_busy)
        else $error("outputs not idle after reset");
    a_prog_run: assert property (take && !native_hi_rate |=> mac_busy[*8] ##1 mac_busy)
        else $error("program pass shorter than nine slots");
    a_busy_refuse: assert property (mac_busy |-> !in_ready)
        else $error("sample accepted while busy");
    a_one_pass: assert property (take |=> !in_ready)
        else $error("second sample taken in same pass");
    a_answer_bound: assert property (take && !native_hi_rate && !out_valid |-> ##[1:12] out_valid)
        else $error("no result within twelve cycles");
    a_head_holds: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("fifo head changed before pop");
    a_rate_follow: assert property ((rst_b && $stable(mclk_family_48k))[*5] |-> rate_is_96k == mclk_family_48k)
        else $error("rate flag does not follow clock family");
    a_busy_emits: assert property ($fell(mac_busy) |-> ##[0:3] out_valid)
        else $error("finished pass left no result");

    c_take: cover property (take && !native_hi_rate);
    c_sat: cover property (out_valid && out_data.sample == amd_pkg::SAT_POS);
    c_full: cover property (!in_ready && out_valid && !out_ready && !mac_busy);
endmodule

bind amd_core amd_core_chk amd_core_chk_i (.clk(clk), .rst_b(rst_b), .coef_wr(coef_wr),
    .mclk_family_48k(mclk_family_48k), .native_hi_rate(native_hi_rate), .in_valid(in_valid),
    .in_ready(in_ready), .in_sample(in_sample), .rate_is_96k(rate_is_96k),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data), .mac_busy(mac_busy));

// [tb/amd_host_model.sv]
// host side model: writes coefficient words into the datapath's coefficient RAM
// assumes a shared clk; the bench calls write_coef after the RAM clear has finished
`timescale 1ns/10ps
module amd_host_model (
    input wire logic              clk,
    output amd_pkg::amd_coef_wr_t coef_wr
);
    initial coef_wr = '0;

    // only the coefficient RAM is reachable from here, top hex digit always zero
    task automatic write_coef(input logic [7:0] addr, input logic [27:0] coef);
        @(negedge clk);
        coef_wr = {1'b1, addr, 4'h0, coef};
        @(negedge clk);
        // released lines show the inverse, never the last value
        coef_wr = {1'b0, ~addr, ~{4'h0, coef}};
    endtask
endmodule

// [tb/tb.sv]
// self-checking bench for amd_core with the host coefficient model
// assumes history taps c1..c4 stay zero so results depend on the current sample only
`timescale 1ns/10ps
module tb;
    logic                  clk;
    logic                  rst_b;
    logic                  mclk48;
    logic                  hi_rate;
    logic                  in_valid;
    logic                  in_ready;
    logic [23:0]           in_sample;
    logic                  rate96;
    logic                  out_valid;
    logic                  out_ready;
    logic                  mac_busy;
    amd_pkg::amd_coef_wr_t coef_wr;
    amd_pkg::amd_sample_t  out_data;
    int                    err_count;
    int                    n_tests;
    logic [2:0]            ch_exp;
    logic [27:0]           k0;
    logic [27:0]           k5;
    logic [27:0]           k6;

    amd_host_model amd_host_model_i (.clk(clk), .coef_wr(coef_wr));
    amd_core amd_core_i (.clk(clk), .rst_b(rst_b), .coef_wr(coef_wr), .mclk_family_48k(mclk48),
        .native_hi_rate(hi_rate), .in_valid(in_valid), .in_ready(in_ready),
        .in_sample(in_sample), .rate_is_96k(rate96), .out_valid(out_valid),
        .out_ready(out_ready), .out_data(out_data), .mac_busy(mac_busy));

    // ************
    // common tasks
    // ************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // about 800 cycles are needed, so 10000 is ample
    initial begin
        #100000;
        err_count++;
        wrap_up;
    end

    task automatic wrap_up;
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // sample aligned under the guard bits, sign extended, noise bits zero
    function automatic logic [31:0] place(input logic [23:0] s);
        return {{4{s[23]}}, s, 4'h0};
    endfunction

    // gain by c0, truncate, gain by c5, truncate, saturating offset c6
    function automatic logic [31:0] model(input logic [23:0] s);
        logic signed [63:0] p;
        logic signed [63:0] r;
        p = $signed({{32{s[23]}}, place(s)}) * $signed({{36{k0[27]}}, k0});
        r = $signed({{32{p[54]}}, p[54:23]});
        p = r * $signed({{36{k5[27]}}, k5});
        r = $signed({{32{p[54]}}, p[54:23]}) + $signed({{36{k6[27]}}, k6});
        if (r > 64'sh7FFFFFFF)
            return amd_pkg::SAT_POS;
        if (r < -64'sh80000000)
            return amd_pkg::SAT_NEG;
        return r[31:0];
    endfunction

    task automatic load(input logic [27:0] c0, input logic [27:0] c5, input logic [27:0] c6);
        k0 = c0;
        k5 = c5;
        k6 = c6;
        for (int a = 0; a < 7; a++)
            amd_host_model_i.write_coef(8'(a), a == 0 ? c0 : a == 5 ? c5 : a == 6 ? c6 : 28'h0);
    endtask

    task automatic send(input logic [23:0] s);
        int n;
        n = 0;
        @(negedge clk);
        in_valid = 1'b1;
        in_sample = s;
        while (in_ready !== 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
        end
        if (n == 300)
            err_count++;
        @(negedge clk);
        in_valid = 1'b0;
        in_sample = ~s;
    endtask

    // far side may stall before taking the head
    task automatic pop(input logic [31:0] exp, input int stall);
        int n;
        n = 0;
        while (out_valid !== 1'b1 && n < 50) begin
            @(negedge clk);
            n++;
        end
        if (n == 50)
            err_count++;
        repeat (stall) @(negedge clk);
        check("out_ch", 32'(out_data.ch), 32'(ch_exp));
        check("out_sample", out_data.sample, exp);
        out_ready = 1'b1;
        @(negedge clk);
        out_ready = 1'b0;
        ch_exp++;
    endtask

    // *********
    // scenarios
    // *********
    task automatic t_reset;
        check("in_ready", 32'(in_ready), 32'h1);
        check("out_valid", 32'(out_valid), 32'h0);
        check("mac_busy", 32'(mac_busy), 32'h0);
    endtask

    task automatic t_rate;
        mclk48 = 1'b1;
        repeat (6) @(negedge clk);
        check("rate_is_96k", 32'(rate96), 32'h1);
        mclk48 = 1'b0;
        repeat (6) @(negedge clk);
        check("rate_is_96k", 32'(rate96), 32'h0);
    endtask

    // tiny gains expose truncation of negatives, negative c0 checks sign handling
    task automatic t_gain;
        load(28'h0800000, 28'h0000001, 28'h0000000);
        for (int i = 0; i < 3; i++) begin
            if (i == 1)
                load(28'h0800000, 28'h0400000, 28'h0000000);
            if (i == 2)
                load(28'hF800000, 28'h0800000, 28'h0000000);
            send(24'hFFFFFF);
            pop(model(24'hFFFFFF), 0);
            send(24'h123457);
            pop(model(24'h123457), 0);
        end
    endtask

    task automatic t_sat;
        load(28'h0800000, 28'h7FFFFFF, 28'h7FFFFFF);
        send(24'h7FFFFF);
        pop(amd_pkg::SAT_POS, 0);
        load(28'h0800000, 28'h7FFFFFF, 28'hF800000);
        send(24'h800000);
        pop(amd_pkg::SAT_NEG, 0);
        send(24'h000001);
        pop(model(24'h000001), 0);
    endtask

    task automatic t_bypass;
        load(28'h0800000, 28'h0C00000, 28'h0000100);
        hi_rate = 1'b1;
        for (int i = 0; i < 8; i++) begin
            send(24'h812345 + 24'(i));
            pop(ch_exp inside {[2:5]} ? place(24'h812345 + 24'(i)) : model(24'h812345 + 24'(i)), 1);
        end
        hi_rate = 1'b0;
    endtask

    task automatic t_fifo;
        for (int i = 0; i < 16; i++)
            send(24'h040000 * 24'(i));
        fork
            send(24'hFEDCBA);
        join_none
        repeat (30) @(negedge clk);
        check("out_valid_full", 32'(out_valid), 32'h1);
        for (int i = 0; i < 16; i++)
            pop(model(24'h040000 * 24'(i)), i % 3);
        pop(model(24'hFEDCBA), 2);
        repeat (3) @(negedge clk);
        check("out_valid_empty", 32'(out_valid), 32'h0);
    endtask

    initial begin
        rst_b = 1'b0;
        mclk48 = 1'b0;
        hi_rate = 1'b0;
        in_valid = 1'b0;
        in_sample = 24'h000000;
        out_ready = 1'b0;
        ch_exp = 3'h0;
        err_count = 0;
        n_tests = 0;
        repeat (5) @(negedge clk);
        rst_b = 1'b1;
        @(negedge clk);
        t_reset;
        // coefficient RAM clears itself for 256 cycles after reset
        repeat (260) @(negedge clk);
        t_rate;
        t_gain;
        t_sat;
        t_bypass;
        t_fifo;
        wrap_up;
    end
endmodule
